// *** rtl/pdc_regs.svh ***
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// Byte addresses of the three configuration bytes, most significant first
`define PDC_ADDR_HI       8'h86
`define PDC_ADDR_MID      8'h87
`define PDC_ADDR_LO       8'h88
// Reset value of the whole configuration word
`define PDC_CFG_RESET     24'h000040
// Field positions
`define PDC_TYPE_MSB      23
`define PDC_TYPE_LSB      20
`define PDC_ALIGN_BIT     19
`define PDC_POL_BIT       18
`define PDC_SRC_MSB       17
`define PDC_SRC_LSB       16
`define PDC_RATE_MSB      15
`define PDC_RATE_LSB      0
// Output-type code that leaves regular clock mode
`define PDC_TYPE_SPECIAL  4'hf
// Read answer for an unmapped address
`define PDC_RD_NONE       8'h00
// Smallest divisor the divider honours
`define PDC_DIV_MIN       24'h000002

`endif

// *** rtl/pdc_pkg.sv ***
package pdc_pkg;

  // Output kind chosen by the configuration word
  typedef enum logic [1:0] {
    PDC_MODE_REGULAR = 2'b00,
    PDC_MODE_LOWFREQ = 2'b01,
    PDC_MODE_FRAME   = 2'b10
  } pdc_mode_t;

  // Source field codes
  typedef enum logic [1:0] {
    PDC_SRC_CLK_A   = 2'b00,
    PDC_SRC_CLK_B   = 2'b01,
    PDC_SRC_LOWFREQ = 2'b10,
    PDC_SRC_CLK_D   = 2'b11
  } pdc_src_t;

endpackage : pdc_pkg

// *** rtl/pdc_div.sv ***
`timescale 1ns/1ps
`include "pdc_regs.svh"

// Counting divider with near 50% duty; high phase takes the larger half
module pdc_div #(
  parameter int W = 24
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] div_i,
  output logic              out_o
);

  logic [W-1:0] cnt;       // Position inside the output period
  logic [W-1:0] div_eff;   // Divisor clamped to the smallest honoured value
  logic [W-1:0] last;      // Final count of a period
  logic [W-1:0] hi_len;    // Length of the high phase
  logic [W-1:0] next_cnt;  // Count after this step

  // Divisor clamp and phase lengths; odd divisors give one extra high step
  always_comb begin
    div_eff  = (div_i < W'(`PDC_DIV_MIN)) ? W'(`PDC_DIV_MIN) : div_i;
    last     = div_eff - W'(1);
    hi_len   = div_eff - (div_eff >> 1);
    next_cnt = (cnt >= last) ? '0 : cnt + W'(1);
  end

  // Counter and registered output
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt   <= '1;  // Parked at the top so the first step opens a full high phase
      out_o <= 1'b0;
    end else if (en_i) begin
      cnt   <= next_cnt;
      out_o <= (next_cnt < hi_len);
    end
  end

endmodule : pdc_div

// *** rtl/pdc_top.sv ***
`timescale 1ns/1ps
`include "pdc_regs.svh"

// Overview of operation
// [RL1] Type not all ones: clock divided by word
// [RL2] Regular mode: all fields form one ratio
// [RL3] Low-frequency mode: twice base over low field
// [RL4] Frame mode: pulse one sibling period wide
// [RL5] Frame spacing: low field sibling periods
// [RL6] Source: A, B, low-frequency, D
// [RL7] Bit 18 picks frame pulse polarity
// [RL8] Bit 19: boundary mid-pulse or first edge
// [RL9] Even or large odd divisors near 50% duty
// [RL10] Software: use divider 8 instead of 7
// [RL11] Frame count follows selected sibling edges
module pdc_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       clk_a_i,
  input  wire logic       clk_b_i,
  input  wire logic       clk_d_i,
  input  wire logic       dbl_base_tick_i,
  output logic            clk_o
);

  logic [23:0]       post_divider_c_config;  // Configuration word
  pdc_pkg::pdc_mode_t mode;                  // Decoded output kind
  pdc_pkg::pdc_mode_t mode_q;                // Kind seen last cycle
  logic [23:0]       divider_value_c;        // Divisor fed to the divider
  logic              div_en;                 // Divider step enable
  logic              div_clr;                // Divider restart
  logic              div_out;                // Divider output
  logic              cfg_wr;                 // Any configuration byte written
  logic              sel_clk;                // Selected sibling clock level
  logic              sel_q;                  // Sibling level last cycle
  logic              sel_rise;               // Sibling rising edge
  logic              sel_fall;               // Sibling falling edge
  logic [15:0]       frm_cnt;                // Sibling periods inside a frame
  logic [15:0]       frm_last;               // Final count of a frame
  logic              frm_pulse;              // Pulse active, before polarity
  logic              align_first;            // Boundary at first pulse edge
  logic              pol_neg;                // Negative-going pulse

  // Output kind from type and source fields
  function automatic pdc_pkg::pdc_mode_t decode_mode(input logic [23:0] cfg);
    if (cfg[`PDC_TYPE_MSB:`PDC_TYPE_LSB] != `PDC_TYPE_SPECIAL) begin
      decode_mode = pdc_pkg::PDC_MODE_REGULAR;
    end else if (cfg[`PDC_SRC_MSB:`PDC_SRC_LSB] == pdc_pkg::PDC_SRC_LOWFREQ) begin
      decode_mode = pdc_pkg::PDC_MODE_LOWFREQ;
    end else begin
      decode_mode = pdc_pkg::PDC_MODE_FRAME;
    end
  endfunction : decode_mode

  // Sibling clock picked by the source field
  function automatic logic pick_clk(input logic [1:0] src, input logic a,
                                    input logic b, input logic d);
    case (src)
      pdc_pkg::PDC_SRC_CLK_A: pick_clk = a;
      pdc_pkg::PDC_SRC_CLK_B: pick_clk = b;
      pdc_pkg::PDC_SRC_CLK_D: pick_clk = d;
      default:                pick_clk = 1'b0;
    endcase
  endfunction : pick_clk

  assign cfg_wr = reg_wr_i && ((reg_addr_i == `PDC_ADDR_HI) ||
                  (reg_addr_i == `PDC_ADDR_MID) || (reg_addr_i == `PDC_ADDR_LO));

  // Byte writes to the configuration word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_divider_c_config <= `PDC_CFG_RESET;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        `PDC_ADDR_HI:  post_divider_c_config[23:16] <= reg_wdata_i;
        `PDC_ADDR_MID: post_divider_c_config[15:8]  <= reg_wdata_i;
        `PDC_ADDR_LO:  post_divider_c_config[7:0]   <= reg_wdata_i;
        default:       ; // Unmapped: ignored
      endcase
    end
  end

  // Registered byte reads; unmapped addresses answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `PDC_RD_NONE;
    end else if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        `PDC_ADDR_HI:  reg_rdata_o <= post_divider_c_config[23:16];
        `PDC_ADDR_MID: reg_rdata_o <= post_divider_c_config[15:8];
        `PDC_ADDR_LO:  reg_rdata_o <= post_divider_c_config[7:0];
        default:       reg_rdata_o <= `PDC_RD_NONE;
      endcase
    end
  end

  // Mode decode and divisor selection
  always_comb begin
    mode        = decode_mode(post_divider_c_config);                 // [RL6]
    align_first = post_divider_c_config[`PDC_ALIGN_BIT];
    pol_neg     = post_divider_c_config[`PDC_POL_BIT];
    sel_clk     = pick_clk(post_divider_c_config[`PDC_SRC_MSB:`PDC_SRC_LSB],
                           clk_a_i, clk_b_i, clk_d_i);                // [RL6]
    frm_last    = post_divider_c_config[`PDC_RATE_MSB:`PDC_RATE_LSB] - 16'h0001;
    if (post_divider_c_config[`PDC_RATE_MSB:`PDC_RATE_LSB] == 16'h0000) begin
      frm_last = 16'h0000; // Zero spacing acts as one period
    end
    case (mode)
      pdc_pkg::PDC_MODE_REGULAR: begin
        divider_value_c = post_divider_c_config; // Whole word is one ratio [RL1] [RL2]
        div_en          = ce_i;
      end
      pdc_pkg::PDC_MODE_LOWFREQ: begin
        divider_value_c = {8'h00, post_divider_c_config[`PDC_RATE_MSB:`PDC_RATE_LSB]};
        div_en          = ce_i && dbl_base_tick_i;                    // [RL3]
      end
      default: begin
        divider_value_c = `PDC_DIV_MIN;
        div_en          = 1'b0;
      end
    endcase
    div_clr = ce_i && (cfg_wr || (mode != mode_q));
  end

  // Shared divider for regular and low-frequency clocks
  pdc_div #(
    .W (24)
  ) u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (div_en),
    .clr_i (div_clr),
    .div_i (divider_value_c),
    .out_o (div_out)
  );

  // Sibling edge detection; inputs are synchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q  <= 1'b0;
      mode_q <= pdc_pkg::PDC_MODE_REGULAR;
    end else if (ce_i) begin
      sel_q  <= sel_clk;
      mode_q <= mode;
    end
  end

  assign sel_rise = sel_clk && !sel_q;
  assign sel_fall = !sel_clk && sel_q;

  // Frame period counter on sibling rising edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (cfg_wr || mode != pdc_pkg::PDC_MODE_FRAME) begin
        frm_cnt <= 16'h0000;
      end else if (sel_rise) begin
        frm_cnt <= (frm_cnt >= frm_last) ? 16'h0000 : frm_cnt + 16'h0001; // [RL5] [RL11]
      end
    end
  end

  // Frame pulse: first-edge alignment starts at the boundary rise,
  // mid-pulse alignment starts at the fall before it; one period wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_pulse <= 1'b0;
    end else if (ce_i) begin
      if (cfg_wr || mode != pdc_pkg::PDC_MODE_FRAME) begin
        frm_pulse <= 1'b0;
      end else if (align_first) begin
        if (sel_rise && frm_cnt >= frm_last) begin
          frm_pulse <= 1'b1;                                         // [RL4] [RL8]
        end else if (sel_rise) begin
          frm_pulse <= 1'b0;
        end
      end else begin
        if (sel_fall && frm_cnt >= frm_last) begin
          frm_pulse <= 1'b1;                                         // [RL4] [RL8]
        end else if (sel_fall) begin
          frm_pulse <= 1'b0;
        end
      end
    end
  end

  // Output flop: polarity applies to frame pulses only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_o <= 1'b0;
    end else if (ce_i) begin
      if (mode == pdc_pkg::PDC_MODE_FRAME) begin
        clk_o <= frm_pulse ^ pol_neg;                                // [RL7]
      end else begin
        clk_o <= div_out; // Duty follows the divider's split [RL9]
      end
    end
  end

  // Helper: length of the current high run of the divider output
  logic [23:0] hi_run;
  always_ff @(posedge clk_i) begin
    if (rst_i || div_clr) begin
      hi_run <= 24'h000000;
    end else if (div_en) begin
      hi_run <= div_out ? hi_run + 24'h000001 : 24'h000000;
    end
  end

  // Regular mode: high run never exceeds the larger half [RL1]
  property p_reg_high_run;
    @(posedge clk_i) disable iff (rst_i)
      (mode == pdc_pkg::PDC_MODE_REGULAR && post_divider_c_config >= `PDC_DIV_MIN)
        |-> hi_run <= post_divider_c_config - (post_divider_c_config >> 1);
  endproperty
  a_reg_high_run: assert property (p_reg_high_run) // [RL1]
    else $error("regular clock high phase too long");

  // Regular mode: each high phase is the larger half of the whole 24-bit word
  property p_reg_ratio;
    @(posedge clk_i) disable iff (rst_i)
      (mode == pdc_pkg::PDC_MODE_REGULAR && post_divider_c_config >= `PDC_DIV_MIN
        && $fell(div_out) && !$past(div_clr))
        |-> hi_run == post_divider_c_config - (post_divider_c_config >> 1);
  endproperty
  a_reg_ratio: assert property (p_reg_ratio) // [RL2]
    else $error("regular divisor not the full word");

  // Low-frequency mode steps only on the doubled base tick
  property p_low_step;
    @(posedge clk_i) disable iff (rst_i)
      (mode == pdc_pkg::PDC_MODE_LOWFREQ && !dbl_base_tick_i && !div_clr) |=> $stable(div_out);
  endproperty
  a_low_step: assert property (p_low_step) // [RL3]
    else $error("low frequency divider stepped without tick");

  // First-edge alignment: boundary rise starts the pulse on the next cycle
  sequence s_boundary_rise;
    ce_i && mode == pdc_pkg::PDC_MODE_FRAME && align_first && !cfg_wr
      && sel_rise && frm_cnt >= frm_last && frm_last != 16'h0000;
  endsequence
  property p_first_edge_start;
    @(posedge clk_i) disable iff (rst_i)
      s_boundary_rise |=> frm_pulse;
  endproperty
  a_first_edge_start: assert property (p_first_edge_start) // [RL4]
    else $error("frame pulse missed boundary edge");

  // Frame counter stays inside the programmed spacing
  property p_frm_range;
    @(posedge clk_i) disable iff (rst_i)
      frm_cnt <= frm_last || $past(cfg_wr);
  endproperty
  a_frm_range: assert property (p_frm_range) // [RL5]
    else $error("frame counter beyond spacing");

  // Source mux follows the field when it selects B
  property p_src_b;
    @(posedge clk_i) disable iff (rst_i)
      post_divider_c_config[`PDC_SRC_MSB:`PDC_SRC_LSB] == pdc_pkg::PDC_SRC_CLK_B
        |-> sel_clk == clk_b_i;
  endproperty
  a_src_b: assert property (p_src_b) // [RL6]
    else $error("source B not selected");

  // Idle frame output sits at the inverse of the active level
  property p_frm_idle;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode == pdc_pkg::PDC_MODE_FRAME && !frm_pulse) |=> clk_o == $past(pol_neg);
  endproperty
  a_frm_idle: assert property (p_frm_idle) // [RL7]
    else $error("frame idle level wrong");

  // Mid-pulse alignment: pulse starts only on a sibling falling edge
  property p_mid_start;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode == pdc_pkg::PDC_MODE_FRAME && !align_first && !cfg_wr
        && !frm_pulse && !sel_fall) |=> !frm_pulse;
  endproperty
  a_mid_start: assert property (p_mid_start) // [RL8]
    else $error("mid-aligned pulse started off a falling edge");

  // Frame counter moves only on a selected sibling rise
  property p_frm_edge;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !sel_rise && !cfg_wr && mode == pdc_pkg::PDC_MODE_FRAME)
        |=> $stable(frm_cnt);
  endproperty
  a_frm_edge: assert property (p_frm_edge) // [RL11]
    else $error("frame counter moved without sibling edge");

endmodule : pdc_top

// *** dv/pdc_sib_model.sv ***
`timescale 1ns/1ps

// Sibling post-divider clocks and low-frequency tick feeding the block
module pdc_sib_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      clk_a_o,
  output logic      clk_b_o,
  output logic      clk_d_o,
  output logic      tick_o
);
  logic [7:0] phase;  // Common phase, wraps at the shared multiple 120

  // Free phase counter so all siblings stay locked to one another
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 8'h00;
    end else begin
      phase <= (phase == 8'h77) ? 8'h00 : phase + 8'h01;
    end
  end

  // Sibling A period 4, B period 6, D period 8, tick every 5 cycles
  assign clk_a_o = (phase % 8'h04) < 8'h02;
  assign clk_b_o = (phase % 8'h06) < 8'h03;
  assign clk_d_o = (phase % 8'h08) < 8'h04;
  assign tick_o  = (phase % 8'h05) == 8'h00;
endmodule : pdc_sib_model

// *** dv/pdc_top_bench.sv ***
`timescale 1ns/1ps
`include "pdc_regs.svh"

// Self-checking bench for post-divider C
module pdc_top_bench;
  logic        clk_i, rst_i, ce_i;     // Clock, reset, enable
  logic [7:0]  reg_addr_i, reg_wdata_i; // Register port address and data
  logic        reg_wr_i, reg_rd_i;     // Register strobes
  logic [7:0]  reg_rdata_o;            // Read answer
  logic        clk_a, clk_b, clk_d;    // Sibling clocks
  logic        tick;                   // Low-frequency tick
  logic        clk_o;                  // Block output
  int          miscompares, tests_run; // Counters

  pdc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .clk_a_i(clk_a), .clk_b_i(clk_b), .clk_d_i(clk_d),
    .dbl_base_tick_i(tick), .clk_o(clk_o));

  pdc_sib_model sib (.clk_i(clk_i), .rst_i(rst_i), .clk_a_o(clk_a), .clk_b_o(clk_b),
    .clk_d_o(clk_d), .tick_o(tick));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // Write the whole word, high byte first, strobe held across bytes
  task automatic wr_cfg(input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      reg_addr_i  <= `PDC_ADDR_HI + 8'(i);
      reg_wdata_i <= v[23-8*i -: 8];
      reg_wr_i    <= 1'b1;
    end
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr_cfg

  // Read one byte; answer lands one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // One full high run then one full low run of the output
  task automatic measure(output logic [31:0] hi, output logic [31:0] lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    @(posedge clk_i); #1;
    while (clk_o !== 1'b0 && n < 5000) begin @(posedge clk_i); #1; n++; end
    while (clk_o !== 1'b1 && n < 5000) begin @(posedge clk_i); #1; n++; end
    while (clk_o === 1'b1 && n < 5000) begin hi++; @(posedge clk_i); #1; n++; end
    while (clk_o === 1'b0 && n < 5000) begin lo++; @(posedge clk_i); #1; n++; end
  endtask : measure

  // Reset values, unmapped read, frozen write, byte write
  task automatic t_regs();
    logic [7:0]  d;
    logic [31:0] hi, lo;
    rd(`PDC_ADDR_HI, d);  check(d, 32'h00);
    rd(`PDC_ADDR_MID, d); check(d, 32'h00);
    rd(`PDC_ADDR_LO, d);  check(d, 32'h40);
    rd(8'h89, d);         check(d, 32'h00);
    measure(hi, lo);      check({hi[15:0], lo[15:0]}, {16'h20, 16'h20});
    @(posedge clk_i);
    ce_i        <= 1'b0;
    reg_addr_i  <= `PDC_ADDR_LO;
    reg_wdata_i <= 8'h11;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    ce_i     <= 1'b1;
    rd(`PDC_ADDR_LO, d);  check(d, 32'h40);
    wr_cfg(24'h123456);
    rd(`PDC_ADDR_HI, d);  check(d, 32'h12);
    rd(`PDC_ADDR_MID, d); check(d, 32'h34);
    rd(`PDC_ADDR_LO, d);  check(d, 32'h56);
    $display("Test registers done");
  endtask : t_regs

  // Regular divide: odd high one longer, even split equally
  task automatic t_regular();
    logic [23:0] tbl [4] = '{24'd7, 24'd8, 24'd41, 24'd2}; // 8 stands for 7
    logic [31:0] hi, lo;
    foreach (tbl[i]) begin
      wr_cfg(tbl[i]);
      measure(hi, lo);
      check(hi, 32'((tbl[i] + 1) / 2));
      check(lo, 32'(tbl[i] / 2));
    end
    $display("Test regular clock done");
  endtask : t_regular

  // Upper fields are part of the ratio: no fast toggling with bit 16 set
  task automatic t_ratio();
    int   tg;
    logic prev;
    tg = 0;
    wr_cfg(24'h010002);
    repeat (3) @(posedge clk_i);
    #1 prev = clk_o;
    repeat (1000) begin
      @(posedge clk_i); #1;
      if (clk_o !== prev) tg++;
      prev = clk_o;
    end
    check(32'(tg <= 1), 32'h1);
    $display("Test full ratio done");
  endtask : t_ratio

  // Low-frequency clock from the doubled base tick
  task automatic t_lowfreq();
    logic [31:0] hi, lo;
    wr_cfg(24'hf20006);
    measure(hi, lo);
    check({hi[15:0], lo[15:0]}, {16'd15, 16'd15});
    wr_cfg(24'hf20004);
    measure(hi, lo);
    check({hi[15:0], lo[15:0]}, {16'd10, 16'd10});
    $display("Test low-frequency clock done");
  endtask : t_lowfreq

  // Frame pulse for every source, polarity and alignment, spacing 3
  task automatic t_frame();
    logic [1:0]  srcs [3] = '{2'b00, 2'b01, 2'b11};
    logic [31:0] per  [3] = '{32'd4, 32'd6, 32'd8};
    logic [31:0] hi, lo;
    foreach (srcs[s]) begin
      for (int k = 0; k < 4; k++) begin
        wr_cfg({4'hf, k[1], k[0], srcs[s], 16'h0003});
        measure(hi, lo);
        check(k[0] ? lo : hi, per[s]);
        check(k[0] ? hi : lo, 32'd2 * per[s]);
      end
    end
    $display("Test frame pulse done");
  endtask : t_frame

  // Hang guard well above the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("Error at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    summarize();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    tests_run   = 0;
    rst_i       = 1'b1;
    ce_i        = 1'b1;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_regular();
    t_ratio();
    t_lowfreq();
    t_frame();
    summarize();
  end
endmodule : pdc_top_bench
